/* src/ccs_consts.svh */
// ccs_consts.svh: offsets, field positions, reset values and timing counts
// for the cycle sequencer; included by the package, both design modules and the bench.
`ifndef CCS_CONSTS_SVH
`define CCS_CONSTS_SVH

// register byte addresses
`define CCS_ADDR_CTRL 8'h00
`define CCS_ADDR_STATUS 8'h04
`define CCS_ADDR_INSTR 8'h08
`define CCS_ADDR_DECODE 8'h0C
`define CCS_ADDR_OFFSET 8'h10

// control register fields and reset value
`define CCS_CTRL_RUN 0
`define CCS_CTRL_START_INHIBIT 1
`define CCS_CTRL_FAST_ENABLE 2
`define CCS_CTRL_RESET 3'h0

// subphase codes (0 = first .. 3 = fourth) for the load and memory-start strobes, the sense load and phase end
`define CCS_SUB_SP_FIRST 2'h1
`define CCS_SUB_ALU_LOAD 2'h2
`define CCS_SUB_SP_SECOND 2'h3
`define CCS_SUB_MEM_START 2'h2
`define CCS_SUB_SENSE_LOAD 2'h3
`define CCS_SUB_LAST 2'h3

// phase codes (0 = first .. 3 = fourth)
`define CCS_PH_FIRST 2'h0
`define CCS_PH_SECOND 2'h1
`define CCS_PH_THIRD 2'h2
`define CCS_PH_LAST 2'h3

// instruction field positions
`define CCS_OPC_HI 15
`define CCS_OPC_LO 12
`define CCS_SUB_HI 11
`define CCS_SUB_LO 8
`define CCS_OFS_MSB 9
`define CCS_INDIRECT_BIT 10
`define CCS_MEMREG_BIT 11

// opcode classes and sub-classes
`define CCS_CLASS_CTRLGRP 4'h0
`define CCS_CLASS_IO 4'h1
`define CCS_CLASS_SKIP 4'h2
`define CCS_SUBCLS_SPECIAL 4'h0
`define CCS_SUBCLS_CONTROL 4'h4
`define CCS_SUBCLS_SHIFT_LO 4'h2
`define CCS_SUBCLS_SHIFT_HI 4'h3
`define CCS_SPECIAL_WAIT 4'h0
`define CCS_SPECIAL_MUL 4'h8
`define CCS_SPECIAL_DIV 4'hA
`define CCS_SKIP_OVF_SET_FWD 4'h0
`define CCS_SKIP_OVF_SET_REV 4'h1
`define CCS_SKIP_OVF_CLR_FWD 4'h8
`define CCS_SKIP_OVF_CLR_REV 4'h9

`endif

/* src/ccs_pkg.sv */
// ccs_pkg: types shared by the cycle sequencer and its field decoder.
// assumes ccs_consts.svh is reachable on the include path.
package ccs_pkg;
  `include "ccs_consts.svh"

  // nine sequence states, each one memory cycle
  typedef enum logic [3:0] {
    SEQ_S1, SEQ_S2, SEQ_S3, SEQ_S4, SEQ_S5, SEQ_S6, SEQ_S7, SEQ_S8, SEQ_S9
  } ccs_seq_t;

  typedef enum logic [1:0] {IO_CONTROL, IO_OUTPUT, IO_INPUT, IO_TEST} ccs_io_mode_t;

  // instruction field decode
  typedef struct packed {
    logic [3:0] opcode_class;
    logic mem_ref;
    logic indirect;
    logic io_instruction;
    logic shift_op;
    logic wait_op;
    logic multiply_op;
    logic divide_op;
    logic control_op;
    logic [2:0] control_sel;
    logic skip_overflow_set;
    logic skip_overflow_clear;
    logic skip_taken;
    logic [15:0] signed_offset;
    logic [15:0] unsigned_offset;
    logic [1:0] index_sel;
    logic [2:0] io_reg_sel;
    ccs_io_mode_t io_mode;
    logic io_from_memory;
  } ccs_decode_t;

  // timing strobes toward the datapath and core memory
  typedef struct packed {
    logic sp_first_load;
    logic alu_load;
    logic sp_second_load;
    logic mem_start;
    logic mdr_clear;
    logic cycle_steal_ack;
    logic interrupt_entry;
  } ccs_strobe_t;
endpackage

/* src/ccs_decode.sv */
// ccs_decode: combinational field decode of the instruction register.
// assumes the word is stable in the caller's instruction register.
`timescale 1ns/100ps
`include "ccs_consts.svh"
module ccs_decode
  import ccs_pkg::*;
(
  input wire logic [15:0] instr_in,
  input wire logic overflow_in,
  output ccs_decode_t fields_out
);

  // control select pattern to one of eight operation codes
  function automatic logic [2:0] ctrl_select(input logic [7:0] sel);
    logic [2:0] code;
    code = 3'h0;
    unique case (sel)
      8'h03: code = 3'h0;
      8'h02: code = 3'h1;
      8'h0C: code = 3'h2;
      8'h08: code = 3'h3;
      8'h30: code = 3'h4;
      8'h20: code = 3'h5;
      8'h40: code = 3'h6;
      8'h80: code = 3'h7;
      default: code = 3'h0;
    endcase
    return code;
  endfunction

  logic [3:0] opc;
  logic [3:0] subcls;
  logic ctrl_grp;
  logic special;
  logic skip_cls;
  assign opc = instr_in[`CCS_OPC_HI:`CCS_OPC_LO];
  assign subcls = instr_in[`CCS_SUB_HI:`CCS_SUB_LO];
  assign ctrl_grp = (opc == `CCS_CLASS_CTRLGRP);
  assign special = ctrl_grp && (subcls == `CCS_SUBCLS_SPECIAL);
  assign skip_cls = (opc == `CCS_CLASS_SKIP);

  // class and sub-class decode
  always_comb begin
    fields_out.opcode_class = opc; // RL20
    fields_out.io_instruction = (opc == `CCS_CLASS_IO);
    fields_out.mem_ref = !ctrl_grp && !skip_cls && (opc != `CCS_CLASS_IO);
    fields_out.indirect = instr_in[`CCS_INDIRECT_BIT];
    fields_out.shift_op = ctrl_grp && (subcls == `CCS_SUBCLS_SHIFT_LO ||
                                       subcls == `CCS_SUBCLS_SHIFT_HI);
    fields_out.wait_op = special && (instr_in[7:4] == `CCS_SPECIAL_WAIT); // RL17
    fields_out.multiply_op = special && (instr_in[7:4] == `CCS_SPECIAL_MUL); // RL17
    fields_out.divide_op = special && (instr_in[7:4] == `CCS_SPECIAL_DIV); // RL17
    fields_out.control_op = ctrl_grp && (subcls == `CCS_SUBCLS_CONTROL); // RL17
    fields_out.control_sel = ctrl_select(instr_in[7:0]); // RL17
    fields_out.skip_overflow_set = skip_cls && (subcls == `CCS_SKIP_OVF_SET_FWD ||
                                   subcls == `CCS_SKIP_OVF_SET_REV); // RL18
    fields_out.skip_overflow_clear = skip_cls && (subcls == `CCS_SKIP_OVF_CLR_FWD ||
                                     subcls == `CCS_SKIP_OVF_CLR_REV); // RL18
    fields_out.skip_taken = (fields_out.skip_overflow_set && overflow_in) ||
                            (fields_out.skip_overflow_clear && !overflow_in); // RL18
    // sign bit replicated up through bit fifteen
    fields_out.signed_offset = {{6{instr_in[`CCS_OFS_MSB]}}, instr_in[9:0]}; // RL12
    fields_out.unsigned_offset = {6'h00, instr_in[9:0]};
    fields_out.index_sel = instr_in[9:8]; // RL13
    fields_out.io_reg_sel = instr_in[10:8]; // RL14
    fields_out.io_mode = ccs_io_mode_t'(instr_in[7:6]); // RL15
    fields_out.io_from_memory = instr_in[`CCS_MEMREG_BIT]; // RL16
  end

endmodule // ccs_decode

/* src/ccs_top.sv */
// ccs_top: cycle sequencer with subphase, phase and sequence state timing,
// memory strobes, cycle-steal and interrupt exits, and field decode.
// assumes pin inputs are asynchronous to clk_sys_in; the register port
// master runs on the same clock.
//
// Notes on behaviour
// [RL1] nine sequence states, one memory cycle each, only those used are visited
// [RL2] each state has four phases run in order
// [RL3] each phase has four subphases stepped straight from the master clock
// [RL4] first scratch-pad load strobe on subphase two
// [RL5] alu result load strobe on subphase three
// [RL6] second scratch-pad load strobe on subphase four
// [RL7] memory start at fourth phase, third subphase unless inhibited
// [RL8] after a memory start, data register cleared in next first phase
// [RL9] pending cycle-steal request, sampled third-to-fourth phase, diverts to state eight
// [RL10] interrupt exit at state five fourth phase instead of returning to state one
// [RL11] fast path jumps from state five phase three to state one phase two
// [RL12] signed offset sign bit replicated up through bit fifteen
// [RL13] index register chosen by instruction bits eight and nine
// [RL14] io register operand chosen by bits eight to ten
// [RL15] io mode from bits six and seven
// [RL16] io operand source memory or register from its own bit
// [RL17] control class digit four with eight ops; wait, multiply, divide under zero
// [RL18] skips on overflow set and on overflow clear
// [RL19] dynamic console switch alters sequence in run mode
// [RL20] class from top four opcode bits after data register moves to instruction register
// [RL21] subphase and phase wrap fourth to first, carrying into next level
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/100ps
`include "ccs_consts.svh"
module ccs_top
  import ccs_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic [15:0] mem_sense_in,
  input wire logic dma_req_in,
  input wire logic int_req_in,
  input wire logic overflow_in,
  input wire logic dynamic_console_switch_in,
  output ccs_strobe_t strobe_out,
  output ccs_seq_t seq_state_out,
  output logic [1:0] phase_out,
  output logic [1:0] clock_subphase_out,
  output logic [15:0] instr_out
);

  // pin synchronisers: first stage feeds only the second
  logic [15:0] sense_meta_reg;
  logic [15:0] sense_sync_reg;
  logic [3:0] pins_meta_reg;
  logic [3:0] pins_sync_reg;
  logic dma_sync;
  logic int_sync;
  logic ovf_sync;
  logic switch_sync;

  // sequencer state
  logic [1:0] sub_reg;
  logic [1:0] sub_next;
  logic [1:0] phase_reg;
  logic [1:0] phase_next;
  ccs_seq_t state_reg;
  ccs_seq_t state_next;
  ccs_seq_t resume_reg;
  ccs_seq_t after_state;
  logic dma_pend_reg;
  logic sense_armed_reg;
  logic [15:0] mdr_reg;
  logic [15:0] ir_reg;
  logic [2:0] ctrl_reg;
  ccs_strobe_t strobe_next;
  ccs_decode_t dec;
  logic running;
  logic end_phase;
  logic end_state;
  logic take_fast;
  logic start_now;

  assign dma_sync = pins_sync_reg[0];
  assign int_sync = pins_sync_reg[1];
  assign ovf_sync = pins_sync_reg[2];
  assign switch_sync = pins_sync_reg[3];
  assign running = ctrl_reg[`CCS_CTRL_RUN];
  assign end_phase = (sub_reg == `CCS_SUB_LAST);
  assign end_state = end_phase && (phase_reg == `CCS_PH_LAST);

  // two-flop synchronisers for every pin
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sense_meta_reg <= 16'h0000;
      sense_sync_reg <= 16'h0000;
      pins_meta_reg <= 4'h0;
      pins_sync_reg <= 4'h0;
    end else begin
      sense_meta_reg <= mem_sense_in;
      sense_sync_reg <= sense_meta_reg;
      pins_meta_reg <= {dynamic_console_switch_in, overflow_in, int_req_in, dma_req_in};
      pins_sync_reg <= pins_meta_reg;
    end
  end

  ccs_decode u_decode (
    .instr_in(ir_reg),
    .overflow_in(ovf_sync),
    .fields_out(dec)
  );

  // fast path only for register-group work, and never with a pending exit
  assign take_fast = ctrl_reg[`CCS_CTRL_FAST_ENABLE] && dec.opcode_class == `CCS_CLASS_CTRLGRP
                     && !dec.shift_op && !dec.multiply_op && !dec.divide_op
                     && !dma_sync && !int_sync && !switch_sync; // RL11 RL19

  // state that follows the current one when no cycle steal intervenes
  always_comb begin
    after_state = SEQ_S1;
    unique case (state_reg)
      SEQ_S1: begin
        if (dec.mem_ref) begin
          after_state = dec.indirect ? SEQ_S3 : SEQ_S5; // RL1
        end else if (dec.io_instruction) begin
          after_state = SEQ_S2;
        end else if (dec.shift_op) begin
          after_state = SEQ_S4;
        end else if (dec.multiply_op || dec.divide_op) begin
          after_state = SEQ_S6;
        end else if (dec.wait_op) begin
          after_state = SEQ_S1;
        end else begin
          after_state = SEQ_S5;
        end
      end
      SEQ_S2: after_state = SEQ_S5;
      SEQ_S3: after_state = SEQ_S5;
      SEQ_S4: after_state = SEQ_S5;
      SEQ_S6: after_state = SEQ_S7;
      SEQ_S7: after_state = SEQ_S5;
      SEQ_S5: begin
        // instruction boundary: interrupt entry replaces the return to state one
        after_state = (int_sync && !switch_sync) ? SEQ_S9 : SEQ_S1; // RL10 RL19
      end
      SEQ_S8: after_state = dma_pend_reg ? SEQ_S8 : resume_reg; // RL9
      SEQ_S9: after_state = SEQ_S1;
      default: after_state = SEQ_S1;
    endcase
  end

  // next subphase, phase and state; halted counters hold their value
  always_comb begin
    sub_next = sub_reg;
    phase_next = phase_reg;
    state_next = state_reg;
    if (running) begin
      sub_next = sub_reg + 2'h1; // RL3 RL21
      if (end_phase) begin
        phase_next = phase_reg + 2'h1; // RL2 RL21
      end
      if (end_phase && phase_reg == `CCS_PH_THIRD && state_reg == SEQ_S5 && take_fast) begin
        phase_next = `CCS_PH_SECOND; // RL11
        state_next = SEQ_S1; // RL11
      end else if (end_state) begin
        if (dma_pend_reg && state_reg != SEQ_S8) begin
          state_next = SEQ_S8; // RL9
        end else begin
          state_next = after_state; // RL1
        end
      end
    end
  end

  // memory start fires unless software inhibits it
  assign start_now = running && !ctrl_reg[`CCS_CTRL_START_INHIBIT] &&
                     phase_next == `CCS_PH_LAST && sub_next == `CCS_SUB_MEM_START; // RL7

  // strobes are computed from next counters so they line up with them
  always_comb begin
    strobe_next.sp_first_load = running && sub_next == `CCS_SUB_SP_FIRST; // RL4
    strobe_next.alu_load = running && sub_next == `CCS_SUB_ALU_LOAD; // RL5
    strobe_next.sp_second_load = running && sub_next == `CCS_SUB_SP_SECOND; // RL6
    strobe_next.mem_start = start_now; // RL7
    strobe_next.mdr_clear = running && sense_armed_reg && phase_next == `CCS_PH_FIRST
                            && sub_next == 2'h0; // RL8
    strobe_next.cycle_steal_ack = running && end_state && state_next == SEQ_S8
                                  && state_reg != SEQ_S8;
    strobe_next.interrupt_entry = running && end_state && state_next == SEQ_S9;
  end

  // counters and sequence state
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sub_reg <= 2'h0;
      phase_reg <= 2'h0;
      state_reg <= SEQ_S1;
    end else begin
      sub_reg <= sub_next;
      phase_reg <= phase_next;
      state_reg <= state_next;
    end
  end

  // cycle-steal sampling between third and fourth phase, and resume point
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dma_pend_reg <= 1'b0;
      resume_reg <= SEQ_S1;
    end else if (running) begin
      if (end_phase && phase_reg == `CCS_PH_THIRD) begin
        dma_pend_reg <= dma_sync; // RL9
      end
      if (end_state && dma_pend_reg && state_reg != SEQ_S8) begin
        resume_reg <= after_state; // RL9
      end
    end
  end

  // a started read is remembered until its sense data have been taken
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sense_armed_reg <= 1'b0;
    end else if (start_now) begin
      sense_armed_reg <= 1'b1; // RL8
    end else if (running && phase_reg == `CCS_PH_FIRST && sub_reg == `CCS_SUB_SENSE_LOAD) begin
      sense_armed_reg <= 1'b0;
    end
  end

  // data register: cleared, then sense output set into it near end of first phase
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mdr_reg <= 16'h0000;
    end else if (strobe_out.mdr_clear) begin
      mdr_reg <= 16'h0000; // RL8
    end else if (running && sense_armed_reg && phase_reg == `CCS_PH_FIRST &&
                 sub_reg == `CCS_SUB_SENSE_LOAD) begin
      mdr_reg <= mdr_reg | sense_sync_reg; // set side only, reset came first
    end
  end

  // fetch after the sense load, in the first cycle of state one phase two;
  // an engaged console switch holds the old word so the instruction repeats
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ir_reg <= 16'h0000;
    end else if (running && state_reg == SEQ_S1 && phase_reg == `CCS_PH_SECOND &&
                 sub_reg == 2'h0 && !switch_sync) begin
      ir_reg <= mdr_reg; // RL20 RL19
    end
  end

  // outputs straight from flops
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strobe_out <= '0;
      seq_state_out <= SEQ_S1;
      phase_out <= 2'h0;
      clock_subphase_out <= 2'h0;
      instr_out <= 16'h0000;
    end else begin
      strobe_out <= strobe_next;
      seq_state_out <= state_next;
      phase_out <= phase_next;
      clock_subphase_out <= sub_next;
      instr_out <= ir_reg;
    end
  end

  // control register write
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_reg <= `CCS_CTRL_RESET;
    end else if (reg_wr_in && reg_addr_in == `CCS_ADDR_CTRL) begin
      ctrl_reg <= reg_wdata_in[2:0];
    end
  end

  // read data stand one cycle after the strobe and are zero otherwise;
  // unmapped addresses read zero
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        `CCS_ADDR_CTRL: reg_rdata_out <= {29'h0000_0000, ctrl_reg};
        `CCS_ADDR_STATUS: reg_rdata_out <= {22'h00_0000, dma_pend_reg, sense_armed_reg,
                                            state_reg, phase_reg, sub_reg};
        `CCS_ADDR_INSTR: reg_rdata_out <= {mdr_reg, ir_reg};
        `CCS_ADDR_DECODE: reg_rdata_out <= {8'h00, dec.opcode_class, dec.control_sel,
                                            dec.io_from_memory, dec.io_mode, dec.io_reg_sel,
                                            dec.index_sel, dec.skip_taken,
                                            dec.skip_overflow_clear, dec.skip_overflow_set,
                                            dec.control_op, dec.divide_op, dec.multiply_op,
                                            dec.wait_op, dec.io_instruction, 1'b0};
        `CCS_ADDR_OFFSET: reg_rdata_out <= {dec.unsigned_offset, dec.signed_offset};
        default: reg_rdata_out <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end

endmodule // ccs_top

/* tb/ccs_top_monitor.sv */
// ccs_top_monitor: port-level timing checks for the cycle sequencer.
// assumes it is bound to ccs_top; one clock, asynchronous active-low reset.
`timescale 1ns/100ps
module ccs_top_monitor
  import ccs_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire ccs_strobe_t strobe_out,
  input wire ccs_seq_t seq_state_out,
  input wire logic [1:0] phase_out,
  input wire logic [1:0] clock_subphase_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  // the three load strobes, each on its own subphase
  sequence load_train_s;
    strobe_out.sp_first_load && clock_subphase_out == 2'h1 ##1
    strobe_out.alu_load && clock_subphase_out == 2'h2 ##1
    strobe_out.sp_second_load && clock_subphase_out == 2'h3;
  endsequence

  // leaving the interrupt state
  sequence s9_exit_s;
    seq_state_out == SEQ_S9 ##1 seq_state_out != SEQ_S9;
  endsequence

  sub_step_a: assert property (
    $changed(clock_subphase_out) |-> clock_subphase_out == $past(clock_subphase_out) + 2'h1)
    else $error("subphase out of step");
  phase_step_a: assert property (
    $changed(phase_out) |-> $past(clock_subphase_out) == 2'h3 &&
    (phase_out == $past(phase_out) + 2'h1 || phase_out == 2'h1 && seq_state_out == SEQ_S1))
    else $error("phase out of step");
  load_order_a: assert property (
    $changed(clock_subphase_out) && clock_subphase_out == 2'h1 |-> load_train_s)
    else $error("load strobes misplaced");
  mem_start_a: assert property (
    strobe_out.mem_start |-> phase_out == 2'h3 && clock_subphase_out == 2'h2)
    else $error("memory start misplaced");
  mdr_clear_a: assert property (
    strobe_out.mem_start |-> ##2 strobe_out.mdr_clear && phase_out == 2'h0)
    else $error("data clear missing after start");
  mdr_cause_a: assert property (
    strobe_out.mdr_clear |-> $past(strobe_out.mem_start, 2))
    else $error("data clear without start");
  state_step_a: assert property (
    $changed(seq_state_out) |-> $past(clock_subphase_out) == 2'h3 &&
    ($past(phase_out) == 2'h3 || $past(phase_out) == 2'h2 && seq_state_out == SEQ_S1))
    else $error("state changed inside a cycle");
  steal_entry_a: assert property (
    $changed(seq_state_out) && seq_state_out == SEQ_S8 |->
    strobe_out.cycle_steal_ack && phase_out == 2'h0)
    else $error("cycle steal entry wrong");
  int_exit_a: assert property (
    strobe_out.interrupt_entry |-> seq_state_out == SEQ_S9 && $past(seq_state_out) == SEQ_S5)
    else $error("interrupt entry wrong");
  s9_return_a: assert property (
    s9_exit_s |-> seq_state_out == SEQ_S1)
    else $error("interrupt state exit wrong");
  fast_jump_a: assert property (
    $changed(seq_state_out) && $past(phase_out) == 2'h2 |->
    $past(seq_state_out) == SEQ_S5 && phase_out == 2'h1 && clock_subphase_out == 2'h0)
    else $error("fast jump wrong");
endmodule // ccs_top_monitor

bind ccs_top ccs_top_monitor u_mon (.clk_sys_in, .reset_n_in, .strobe_out, .seq_state_out,
  .phase_out, .clock_subphase_out);

/* tb/ccs_mem_model.sv */
// ccs_mem_model: core memory sense output answering each memory start.
// assumes the bench supplies the word to return; no address is modelled.
`timescale 1ns/100ps
module ccs_mem_model (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic mem_start_in,
  input wire logic [15:0] word_in,
  output logic [15:0] sense_out
);
  logic [3:0] window_reg;

  // sense data stand only for a short window after each start
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      window_reg <= 4'h0;
    end else if (mem_start_in) begin
      window_reg <= 4'h9;
    end else if (window_reg != 4'h0) begin
      window_reg <= window_reg - 4'h1;
    end
  end

  // outside it the inverse word shows, so a late capture fails
  assign sense_out = (window_reg != 4'h0) ? word_in : ~word_in;
endmodule // ccs_mem_model

/* tb/cpu_cycle_sequencer_tb.sv */
// cpu_cycle_sequencer_tb: self-checking bench for the cycle sequencer.
// assumes the design, monitor and memory model are compiled first.
`timescale 1ns/100ps
`include "ccs_consts.svh"
module cpu_cycle_sequencer_tb
  import ccs_pkg::*;
;
  logic clk_sys_in, reset_n_in, reg_wr_in, reg_rd_in, rd_pend;
  logic dma_req_in, int_req_in, overflow_in, console_sw;
  logic [7:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, ms, sp, hits;
  logic [15:0] mem_sense_in, instr_out, word, w;
  logic [7:0] ctl_codes [8];
  logic [31:0] exp_q [$];
  logic [31:0] mask_q [$];
  ccs_strobe_t strobe_out;
  ccs_seq_t seq_state_out;
  logic [1:0] phase_out, clock_subphase_out;
  int error_cnt, n_checks, seed, n;

  ccs_top u_dut (.clk_sys_in, .reset_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .mem_sense_in, .dma_req_in, .int_req_in, .overflow_in, .strobe_out,
    .dynamic_console_switch_in(console_sw), .seq_state_out, .phase_out, .clock_subphase_out,
    .instr_out);
  ccs_mem_model u_mem (.clk_sys_in, .reset_n_in, .mem_start_in(strobe_out.mem_start),
    .word_in(word), .sense_out(mem_sense_in));

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic finish_test();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask

  // the watcher compares the noted word when the data appear
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk_sys_in);
    exp_q.push_back(e);
    mask_q.push_back(m);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
  endtask

  // bounded wait for entry into a state
  task automatic wait_state(input ccs_seq_t s);
    ccs_seq_t prev;
    prev = seq_state_out;
    for (n = 0; n < 300; n++) begin
      @(negedge clk_sys_in);
      if (seq_state_out === s && clock_subphase_out === 2'h0 &&
          (phase_out === 2'h0 || prev !== s)) return;
      prev = seq_state_out;
    end
    error_cnt++;
    finish_test();
  endtask

  // after two entries into state one the new word is decoded
  task automatic check_word(input logic [15:0] v, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk_sys_in);
    word <= v;
    wait_state(SEQ_S1);
    wait_state(SEQ_S1);
    repeat (6) @(negedge clk_sys_in);
    check({16'h0000, instr_out}, {16'h0000, v});
    reg_rd(`CCS_ADDR_INSTR, {v, v}, 32'hFFFF_FFFF);
    reg_rd(`CCS_ADDR_DECODE, e, m);
    reg_rd(`CCS_ADDR_OFFSET, {6'h00, v[9:0], {6{v[9]}}, v[9:0]}, 32'hFFFF_FFFF);
  endtask

  task automatic count32();
    @(posedge clk_sys_in);
    ms = 32'h0000_0000;
    sp = 32'h0000_0000;
    repeat (32) begin
      @(negedge clk_sys_in);
      ms = ms + 32'(strobe_out.mem_start);
      sp = sp + 32'(strobe_out.sp_first_load);
    end
  endtask

  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  // read data stand only in the cycle after the strobe
  always @(negedge clk_sys_in) begin
    if (rd_pend) check(reg_rdata_out & mask_q.pop_front(), exp_q.pop_front());
    rd_pend = reg_rd_in;
  end

  initial begin
    seed = 87698;
    error_cnt = 0;
    n_checks = 0;
    rd_pend = 1'b0;
    reset_n_in = 1'b0;
    {reg_wr_in, reg_rd_in, dma_req_in, int_req_in, overflow_in, console_sw} = 6'h00;
    reg_addr_in = 8'h00;
    reg_wdata_in = 32'h0000_0000;
    word = 16'h0000;
    ctl_codes = '{8'h03, 8'h02, 8'h0C, 8'h08, 8'h30, 8'h20, 8'h40, 8'h80};
    repeat (20) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    reg_rd(`CCS_ADDR_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
    reg_rd(8'h14, 32'h0000_0000, 32'hFFFF_FFFF);
    reg_wr(`CCS_ADDR_CTRL, 32'h0000_0001);
    reg_rd(`CCS_ADDR_CTRL, 32'h0000_0001, 32'hFFFF_FFFF);
    // wait, multiply and divide under digit zero
    for (int i = 0; i < 3; i++) begin
      w = (i == 0) ? 16'h0000 : ((i == 1) ? 16'h0080 : 16'h00A0);
      check_word(w, 32'h0000_0004 << i, 32'h00F0_003E);
    end
    for (int i = 0; i < 8; i++) begin
      check_word({8'h04, ctl_codes[i]}, 32'h0000_0020 | (32'(i) << 17), 32'h00FE_003E);
    end
    // every io mode, register and source fields varied
    for (int i = 0; i < 4; i++) begin
      w = {4'h1, i[0], 3'(i + 3), i[1:0], 6'h00};
      check_word(w, {8'h00, 4'h1, 3'h0, w[11], w[7:6], w[10:8], 11'h002}, 32'h00F1_F802);
    end
    // both skip forms against both overflow levels
    for (int i = 0; i < 4; i++) begin
      overflow_in <= i[0];
      w = i[1] ? 16'h2805 : 16'h2005;
      check_word(w, 32'h0020_0000 | (i[1] ? 32'h0000_0080 : 32'h0000_0040) |
                 ((i[1] ^ i[0]) ? 32'h0000_0100 : 32'h0000_0000), 32'h00F0_01C0);
    end
    // random memory references, sign bit alternated
    for (int i = 0; i < 4; i++) begin
      w = 16'($random(seed));
      w[15:12] = 4'hC;
      w[9] = i[0];
      check_word(w, {8'h00, 4'hC, 9'h000, w[9:8], 9'h000}, 32'h00F0_0600);
    end
    count32();
    check(sp, 32'h0000_0008);
    check(ms, 32'h0000_0002);
    reg_wr(`CCS_ADDR_CTRL, 32'h0000_0003);
    count32();
    check(ms, 32'h0000_0000);
    reg_wr(`CCS_ADDR_CTRL, 32'h0000_0001);
    dma_req_in <= 1'b1;
    wait_state(SEQ_S8);
    check(32'(strobe_out.cycle_steal_ack), 32'h0000_0001);
    @(posedge clk_sys_in);
    dma_req_in <= 1'b0;
    check_word(16'hC000, 32'h00C0_0000, 32'h00F0_0000);
    int_req_in <= 1'b1;
    wait_state(SEQ_S9);
    check(32'(strobe_out.interrupt_entry), 32'h0000_0001);
    @(posedge clk_sys_in);
    int_req_in <= 1'b0;
    wait_state(SEQ_S1);
    check(32'(n), 32'h0000_000F);
    // switch held: no interrupt entry and the instruction stays put
    @(posedge clk_sys_in);
    console_sw <= 1'b1;
    int_req_in <= 1'b1;
    word <= 16'h1E80;
    hits = 32'h0000_0000;
    repeat (64) begin
      @(negedge clk_sys_in);
      if (seq_state_out === SEQ_S9) hits++;
    end
    check(hits, 32'h0000_0000);
    check({16'h0000, instr_out}, 32'h0000_C000);
    @(posedge clk_sys_in);
    console_sw <= 1'b0;
    int_req_in <= 1'b0;
    check_word(16'h0403, 32'h0000_0020, 32'h00FE_003E);
    reg_wr(`CCS_ADDR_CTRL, 32'h0000_0005);
    wait_state(SEQ_S5);
    wait_state(SEQ_S1);
    check(32'(n), 32'h0000_000B);
    check({30'h0000_0000, phase_out}, 32'h0000_0001);
    // mid-run reset returns to the halted first state
    @(posedge clk_sys_in);
    reset_n_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    check({24'h00_0000, seq_state_out, phase_out, clock_subphase_out}, 32'h0000_0000);
    reset_n_in <= 1'b1;
    reg_rd(`CCS_ADDR_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
    repeat (3) @(posedge clk_sys_in);
    finish_test();
  end
endmodule // cpu_cycle_sequencer_tb
